// *** rtl/timer8_pwm_waveform_unit.sv ***
// 8-bit timer/counter with one compare channel and waveform generator
// assumes a single ahb-lite master; all inputs synchronous to hclk
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - mode bits pick normal, phase-correct, clear-on-compare or fast pwm
// - pwm modes latch compare value at top; others apply it at once
// - phase-correct counts up to max then back down to bottom
// - phase-correct holds max for one timer tick before counting down
// - phase-correct is 8-bit; overflow flag set on the tick that turns at bottom
// - phase-correct action 2 clears up/sets down, 3 the opposite
// - phase-correct action 2 compare at bottom gives constant low, at max high, 3 the opposite
// - fast pwm action 2 clears on match sets at top, 3 opposite
// - fast pwm action 1 toggles output on every compare match
// - pwm with compare equal top and action high bit: act at top
// - non-pwm action: 0 off, 1 toggle, 2 clear, 3 set on match
// - nonzero action overrides port; driver enabled only by direction bit
// - force strobe applies action at once in non-pwm modes only
// - force sets no flag, clears no counter, and reads back zero
// - clock select: stop, divide 1/8/32/256/1024, external fall or rise
// - external edges count even when the pin is an output
// - counter read/write anytime; write blocks next tick's compare match
// - fully synchronous, timer clock is only a count enable pulse
// - mode register bit layout, all bits reset to zero
// - clear-on-compare resets counter to zero on a match
// - fast pwm wraps from max to bottom on next tick
// - flags cleared by acknowledge input or by writing one
module timer8_pwm_waveform_unit
  import timer8_pkg::*;
(
  input  wire  logic                    hclk,
  input  wire  logic                    hresetn,
  input  wire  logic                    hsel,
  input  wire  logic [7:0]              haddr,
  input  wire  logic [1:0]              htrans,
  input  wire  logic                    hwrite,
  input  wire  logic [2:0]              hsize,
  input  wire  logic [31:0]             hwdata,
  input  wire  logic                    hready,
  output var   logic [31:0]             hrdata,
  output var   logic                    hreadyout,
  output var   logic                    hresp,
  input  wire  logic                    ext_count_pin,
  input  wire  logic                    compare_ack,
  input  wire  logic                    overflow_ack,
  output var   timer8_pkg::pin_drive_t  pin_q,
  output var   logic                    compare_flag,
  output var   logic                    overflow_flag
);
  import timer8_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // bus slave
  logic           wr_pend_q;
  logic [7:0]     addr_q;
  logic [7:0]     mode_ctrl_q;
  logic [7:0]     count_reg_q;
  logic [7:0]     compare_value_reg_q;
  logic [7:0]     cmp_active_q;
  logic [1:0]     port_ctrl_q;
  logic           up_q;
  logic           block_q;
  logic           wave_q;
  logic           cmp_flag_q;
  logic           ovf_flag_q;
  logic           ext_q;
  logic [9:0]     pre_q;

  wire            addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire            wr_mode  = wr_pend_q && (addr_q == MODE_CTRL_OFS);
  wire            wr_count = wr_pend_q && (addr_q == COUNT_OFS);
  wire            wr_cmp   = wr_pend_q && (addr_q == COMPARE_OFS);
  wire            wr_flags = wr_pend_q && (addr_q == FLAGS_OFS);
  wire            wr_port  = wr_pend_q && (addr_q == PORT_CTRL_OFS);

  wave_mode_sel_t wave_mode_sel;
  clock_sel_t     clock_sel;
  logic [1:0]     compare_out_action;
  logic           pwm_mode;

  assign wave_mode_sel = wave_mode_sel_t'({mode_ctrl_q[MODE_HI_BIT],
                                           mode_ctrl_q[MODE_LO_BIT]});
  assign clock_sel = clock_sel_t'(mode_ctrl_q[CLK_SEL_HI:0]);
  assign compare_out_action = mode_ctrl_q[ACT_HI_BIT:ACT_LO_BIT];
  assign pwm_mode = mode_ctrl_q[MODE_LO_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite && (hsize == HSIZE_WORD);
      addr_q    <= haddr;
    end
  end

  // zero-wait slave; data phase always completes in one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is registered in the address phase so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
    begin
      if (haddr == MODE_CTRL_OFS)
        hrdata <= {24'h000000, 1'b0, mode_ctrl_q[6:0]};
      else if (haddr == COUNT_OFS)
        hrdata <= {24'h000000, count_reg_q};
      else if (haddr == COMPARE_OFS)
        hrdata <= {24'h000000, compare_value_reg_q};
      else if (haddr == FLAGS_OFS)
        hrdata <= {30'h0, cmp_flag_q, ovf_flag_q};
      else if (haddr == PORT_CTRL_OFS)
        hrdata <= {30'h0, port_ctrl_q};
      else
        hrdata <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_ctrl_q <= MODE_CTRL_RST;
    else if (wr_mode)
      mode_ctrl_q <= {1'b0, hwdata[6:0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_ctrl_q <= 2'b00;
    else if (wr_port)
      port_ctrl_q <= hwdata[1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_value_reg_q <= 8'h00;
    else if (wr_cmp)
      compare_value_reg_q <= hwdata[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // tick generation
  logic ext_edge;
  logic timer_tick;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_q <= 10'h000;
      ext_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + 10'h001;
      ext_q <= ext_count_pin;
    end
  end

  always_comb
  begin
    ext_edge = 1'b0;
    case (clock_sel)
      CS_EXT_FALL: ext_edge = ext_q && !ext_count_pin;
      CS_EXT_RISE: ext_edge = !ext_q && ext_count_pin;
      default:     ext_edge = 1'b0;
    endcase
  end

  always_comb
  begin
    timer_tick = 1'b0;
    case (clock_sel)
      CS_STOP:     timer_tick = 1'b0;
      CS_DIV1:     timer_tick = 1'b1;
      CS_DIV8:     timer_tick = (pre_q[2:0] == DIV_8[2:0]);
      CS_DIV32:    timer_tick = (pre_q[4:0] == DIV_32[4:0]);
      CS_DIV256:   timer_tick = (pre_q[7:0] == DIV_256[7:0]);
      CS_DIV1024:  timer_tick = (pre_q == DIV_1024);
      default:     timer_tick = ext_edge;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // counter
  logic [7:0] top;
  logic       match;
  logic       at_top;

  assign top   = (wave_mode_sel == MODE_CLEAR) ? compare_value_reg_q
                                               : CNT_MAX;
  assign match = (count_reg_q == cmp_active_q) && !block_q;
  assign at_top = (count_reg_q == top);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      block_q <= 1'b0;
    else if (wr_count)
      block_q <= 1'b1;
    else if (timer_tick)
      block_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg_q <= 8'h00;
      up_q        <= 1'b1;
    end
    else if (wr_count)
      count_reg_q <= hwdata[7:0];
    else if (timer_tick)
    begin
      case (wave_mode_sel)
        MODE_PHASE:
        begin
          // max stands for a single tick, so one period is 510 ticks
          if (up_q && count_reg_q == CNT_MAX)
          begin
            up_q        <= 1'b0;
            count_reg_q <= count_reg_q - 8'h01;
          end
          else if (!up_q && count_reg_q == CNT_BOTTOM)
          begin
            up_q        <= 1'b1;
            count_reg_q <= count_reg_q + 8'h01;
          end
          else if (up_q)
            count_reg_q <= count_reg_q + 8'h01;
          else
            count_reg_q <= count_reg_q - 8'h01;
        end
        MODE_CLEAR:
        begin
          if (match)
            count_reg_q <= CNT_BOTTOM;
          else
            count_reg_q <= count_reg_q + 8'h01;
        end
        default:
        begin
          up_q        <= 1'b1;
          count_reg_q <= count_reg_q + 8'h01;
        end
      endcase
    end
  end

  // double buffer: pwm copies at top, others follow the register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmp_active_q <= 8'h00;
    else if (!pwm_mode)
      cmp_active_q <= compare_value_reg_q;
    else if (timer_tick && at_top)
      cmp_active_q <= compare_value_reg_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // flags; a hardware set wins over a clear in the same cycle
  logic ovf_evt;
  logic cmp_evt;

  always_comb
  begin
    ovf_evt = 1'b0;
    if (timer_tick && !wr_count)
    begin
      if (wave_mode_sel == MODE_PHASE)
        ovf_evt = !up_q && count_reg_q == CNT_BOTTOM;
      else
        ovf_evt = count_reg_q == CNT_MAX;
    end
  end

  assign cmp_evt = timer_tick && !wr_count && match;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end
    else
    begin
      if (cmp_evt)
        cmp_flag_q <= 1'b1;
      else if (compare_ack || (wr_flags && hwdata[CMP_FLAG_BIT]))
        cmp_flag_q <= 1'b0;
      if (ovf_evt)
        ovf_flag_q <= 1'b1;
      else if (overflow_ack || (wr_flags && hwdata[OVF_FLAG_BIT]))
        ovf_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      compare_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end
    else
    begin
      compare_flag  <= cmp_flag_q;
      overflow_flag <= ovf_flag_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // waveform generator
  logic force_go;
  logic cmp_hit;
  logic top_hit;
  logic top_special;

  // software keeps the strobe low in pwm modes; it is ignored there anyway
  assign force_go = wr_mode && hwdata[FORCE_BIT] && !hwdata[MODE_LO_BIT];
  assign top_special = compare_out_action[1] && cmp_active_q == CNT_MAX;
  assign cmp_hit = cmp_evt && !(pwm_mode && top_special);
  assign top_hit = timer_tick && count_reg_q == CNT_MAX;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wave_q <= 1'b0;
    else if (force_go)
    begin
      case (hwdata[ACT_HI_BIT:ACT_LO_BIT])
        2'b01:   wave_q <= !wave_q;
        2'b10:   wave_q <= 1'b0;
        2'b11:   wave_q <= 1'b1;
        default: wave_q <= wave_q;
      endcase
    end
    else
    begin
      case (wave_mode_sel)
        MODE_FAST:
        begin
          if (compare_out_action == 2'b01 && cmp_evt)
            wave_q <= !wave_q;
          else if (compare_out_action[1] && top_hit && !wr_count)
            wave_q <= !compare_out_action[0];
          else if (compare_out_action[1] && cmp_hit)
            wave_q <= compare_out_action[0];
        end
        MODE_PHASE:
        begin
          // a bottom match is the turn and acts as up-count, so a bottom
          // compare keeps the up level; a max compare is handled at top
          if (compare_out_action[1] && top_special && top_hit && up_q)
            wave_q <= !compare_out_action[0];
          else if (compare_out_action[1] && cmp_hit)
            wave_q <= (up_q || count_reg_q == CNT_BOTTOM)
                      ? compare_out_action[0] : !compare_out_action[0];
        end
        default:
        begin
          if (cmp_hit)
          begin
            case (compare_out_action)
              2'b01:   wave_q <= !wave_q;
              2'b10:   wave_q <= 1'b0;
              2'b11:   wave_q <= 1'b1;
              default: wave_q <= wave_q;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_q <= '0;
    else
    begin
      pin_q.wave_out <= wave_q;
      pin_q.pin_out  <= (compare_out_action != 2'b00) ? wave_q
                        : port_ctrl_q[PORT_DATA_BIT];
      pin_q.pin_oe   <= port_ctrl_q[PORT_DIR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_force_no_flag;
    @(posedge hclk) disable iff (!hresetn)
    (force_go && !cmp_evt) |=> !$rose(cmp_flag_q);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced compare raised the compare flag");

  property p_mode_force_zero;
    @(posedge hclk) disable iff (!hresetn)
    wr_mode |=> !mode_ctrl_q[FORCE_BIT];
  endproperty
  a_mode_force_zero: assert property (p_mode_force_zero)
    else $error("force strobe stored in mode register");

  property p_ctc_clear;
    @(posedge hclk) disable iff (!hresetn)
    (wave_mode_sel == MODE_CLEAR && cmp_evt) |=> count_reg_q == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("counter not cleared on compare in clear mode");

  property p_fast_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (wave_mode_sel == MODE_FAST && timer_tick && !wr_count
     && count_reg_q == 8'hFF) |=> count_reg_q == 8'h00;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap)
    else $error("fast pwm did not wrap to bottom");

  sequence s_reach_max;
    wave_mode_sel == MODE_PHASE && timer_tick && up_q && !wr_count
      && count_reg_q == 8'hFF;
  endsequence
  property p_phase_hold;
    @(posedge hclk) disable iff (!hresetn)
    s_reach_max |=> count_reg_q == 8'hFE && !up_q;
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase correct did not hold max");

  property p_phase_ovf;
    @(posedge hclk) disable iff (!hresetn)
    (wave_mode_sel == MODE_PHASE && timer_tick && !wr_count && !up_q
     && count_reg_q == 8'h00) |=> ovf_flag_q;
  endproperty
  a_phase_ovf: assert property (p_phase_ovf)
    else $error("overflow flag not set at bottom");

  property p_write_blocks;
    @(posedge hclk) disable iff (!hresetn)
    wr_count |=> block_q;
  endproperty
  a_write_blocks: assert property (p_write_blocks)
    else $error("counter write did not block next compare");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
    (clock_sel == CS_STOP && !wr_count) |=> $stable(count_reg_q);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_cmp_set;
    @(posedge hclk) disable iff (!hresetn)
    cmp_evt |=> cmp_flag_q ##1 compare_flag;
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("compare flag not raised on match");

  property p_pin_oe;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> pin_q.pin_oe == $past(port_ctrl_q[PORT_DIR_BIT]);
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin driver enable does not follow direction bit");
endmodule

`default_nettype wire

// *** include/timer8_pkg.sv ***
// package for the 8-bit timer with waveform unit
// assumes an ahb-lite slave with 32-bit data, one aligned word per register
package timer8_pkg;
  localparam logic [7:0] MODE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] COUNT_OFS       = 8'h04;
  localparam logic [7:0] COMPARE_OFS     = 8'h08;
  localparam logic [7:0] FLAGS_OFS       = 8'h0C;
  localparam logic [7:0] PORT_CTRL_OFS   = 8'h10;
  localparam int FORCE_BIT      = 7;
  localparam int MODE_LO_BIT    = 6;
  localparam int ACT_HI_BIT     = 5;
  localparam int ACT_LO_BIT     = 4;
  localparam int MODE_HI_BIT    = 3;
  localparam int CLK_SEL_HI     = 2;
  localparam int CMP_FLAG_BIT   = 1;
  localparam int OVF_FLAG_BIT   = 0;
  localparam int PORT_DIR_BIT   = 1;
  localparam int PORT_DATA_BIT  = 0;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM    = 8'h00;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_32   = 10'h01F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_PHASE  = 2'b01,
    MODE_CLEAR  = 2'b10,
    MODE_FAST   = 2'b11
  } wave_mode_sel_t;

  typedef enum logic [2:0]
  {
    CS_STOP  = 3'b000,
    CS_DIV1  = 3'b001,
    CS_DIV8  = 3'b010,
    CS_DIV32 = 3'b011,
    CS_DIV256  = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_sel_t;

  typedef struct packed
  {
    logic       wave_out;
    logic       pin_out;
    logic       pin_oe;
  } pin_drive_t;
endpackage

// *** dv/timer8_pwm_waveform_unit_tb.sv ***
// self-checking testbench for the 8-bit timer with waveform unit
// assumes the unit is the only ahb-lite slave and the bench is the master
`timescale 1ns/10ps
`default_nettype none
module timer8_pwm_waveform_unit_tb;
  import timer8_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_count_pin;
  logic        compare_ack;
  logic        overflow_ack;
  pin_drive_t  pin_q;
  logic        compare_flag;
  logic        overflow_flag;
  int          errors;
  int          checks;
  int          cycles;
  logic [31:0] rd;
  logic [7:0]  seq [4] = '{8'hFE, 8'hFF, 8'hFE, 8'hFD};
  int          dv [5] = '{1, 8, 32, 256, 1024};

  assign hready = hreadyout;

  timer8_pwm_waveform_unit u_timer8_pwm_waveform_unit (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hready),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .ext_count_pin (ext_count_pin),
    .compare_ack   (compare_ack),
    .overflow_ack  (overflow_ack),
    .pin_q         (pin_q),
    .compare_flag  (compare_flag),
    .overflow_flag (overflow_flag)
  );

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hang in any wait below ends here rather than running forever
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
      errors++;
    end
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    check(n, d, exp);
  endtask

  function automatic logic [31:0] mc(input logic f, input logic [1:0] m,
                                     input logic [1:0] act,
                                     input logic [2:0] cs);
    mc = {24'h0, f, m[0], act, m[1], cs};
  endfunction

  // one full pulse on the count pin per step, slow enough for the sync
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_count_pin <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask

  task automatic ack(input logic c);
    @(posedge hclk);
    compare_ack  <= c;
    overflow_ack <= ~c;
    @(posedge hclk);
    compare_ack  <= 1'b0;
    overflow_ack <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    ext_count_pin = 1'b0;
    compare_ack = 1'b0;
    overflow_ack = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("mode reset", MODE_CTRL_OFS, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    check("hresp", 32'(hresp), 32'h0);
    check("hreadyout", 32'(hreadyout), 32'h1);
    wr(MODE_CTRL_OFS, 32'h7F);
    rd_chk("mode rw", MODE_CTRL_OFS, 32'h7F);
    wr(MODE_CTRL_OFS, 32'hB7);
    rd_chk("force reads 0", MODE_CTRL_OFS, 32'h37);
    $display("test registers done");

    wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_EXT_RISE));
    wr(COUNT_OFS, 32'hFE);
    wr(FLAGS_OFS, 32'h3);
    tick(1);
    rd_chk("count max", COUNT_OFS, 32'hFF);
    rd_chk("no ovf yet", FLAGS_OFS, 32'h0);
    tick(1);
    rd_chk("count wrap", COUNT_OFS, 32'h00);
    rd_chk("ovf at max", FLAGS_OFS, 32'h1);
    check("ovf port", 32'(overflow_flag), 32'h1);
    ack(1'b0);
    rd_chk("ovf acked", FLAGS_OFS, 32'h0);
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_EXT_FALL));
    @(posedge hclk);
    ext_count_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    rd_chk("rise ignored", COUNT_OFS, 32'h00);
    ext_count_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    rd_chk("fall counts", COUNT_OFS, 32'h01);
    $display("test external clock done");

    wr(PORT_CTRL_OFS, 32'h3);
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_CLEAR, 2'b00, CS_STOP));
    repeat (4) @(posedge hclk);
    check("pin oe", 32'(pin_q.pin_oe), 32'h1);
    check("port data", 32'(pin_q.pin_out), 32'h1);
    wr(COMPARE_OFS, 32'h3);
    wr(COUNT_OFS, 32'h3);
    wr(FLAGS_OFS, 32'h3);
    wr(MODE_CTRL_OFS, mc(1'b1, MODE_CLEAR, 2'b10, CS_STOP));
    repeat (4) @(posedge hclk);
    check("force clear", 32'(pin_q.wave_out), 32'h0);
    wr(MODE_CTRL_OFS, mc(1'b1, MODE_CLEAR, 2'b11, CS_STOP));
    repeat (4) @(posedge hclk);
    check("force set", 32'(pin_q.wave_out), 32'h1);
    wr(MODE_CTRL_OFS, mc(1'b1, MODE_CLEAR, 2'b01, CS_STOP));
    repeat (4) @(posedge hclk);
    check("force toggle", 32'(pin_q.wave_out), 32'h0);
    check("pin follows", 32'(pin_q.pin_out), 32'h0);
    rd_chk("force no clear", COUNT_OFS, 32'h3);
    rd_chk("force no flag", FLAGS_OFS, 32'h0);
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_CLEAR, 2'b01, CS_EXT_RISE));
    wr(COUNT_OFS, 32'h0);
    tick(3);
    rd_chk("ctc at top", COUNT_OFS, 32'h3);
    tick(1);
    rd_chk("ctc cleared", COUNT_OFS, 32'h0);
    rd_chk("ctc flags", FLAGS_OFS, 32'h2);
    check("ctc toggle", 32'(pin_q.wave_out), 32'h1);
    check("cmp port", 32'(compare_flag), 32'h1);
    ack(1'b1);
    rd_chk("cmp acked", FLAGS_OFS, 32'h0);
    $display("test compare match done");

    wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_EXT_RISE));
    wr(COMPARE_OFS, 32'h5);
    wr(COUNT_OFS, 32'h5);
    tick(1);
    rd_chk("write count", COUNT_OFS, 32'h6);
    rd_chk("match blocked", FLAGS_OFS, 32'h0);
    wr(COUNT_OFS, 32'h3);
    tick(3);
    rd_chk("match seen", FLAGS_OFS, 32'h2);
    wr(FLAGS_OFS, 32'h2);
    rd_chk("cmp w1c", FLAGS_OFS, 32'h0);
    $display("test counter write done");

    wr(COMPARE_OFS, 32'h2);
    // pwm modes are always written with the force strobe low
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_FAST, 2'b10, CS_EXT_RISE));
    wr(COUNT_OFS, 32'hFE);
    tick(3);
    check("fast set top", 32'(pin_q.wave_out), 32'h1);
    wr(COMPARE_OFS, 32'h80);
    tick(2);
    check("old cmp used", 32'(pin_q.wave_out), 32'h0);
    tick(254);
    rd_chk("fast wrap", COUNT_OFS, 32'h1);
    tick(2);
    check("new cmp used", 32'(pin_q.wave_out), 32'h1);
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_FAST, 2'b01, CS_EXT_RISE));
    tick(126);
    check("fast toggle", 32'(pin_q.wave_out), 32'h0);
    $display("test fast pwm done");

    wr(MODE_CTRL_OFS, mc(1'b0, MODE_PHASE, 2'b00, CS_EXT_RISE));
    wr(COUNT_OFS, 32'hFD);
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      rd_chk("dual slope", COUNT_OFS, 32'(seq[i]));
    end
    wr(FLAGS_OFS, 32'h3);
    wr(COUNT_OFS, 32'h2);
    // the flag rises on the tick that turns at bottom, not on the turn at max
    tick(3);
    rd_chk("ovf at bottom", FLAGS_OFS, 32'h1);
    tick(1);
    rd_chk("turn at bottom", COUNT_OFS, 32'h2);
    // a non-pwm write loads the compare at once; pwm then keeps it
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_STOP));
    wr(COMPARE_OFS, 32'h3);
    wr(MODE_CTRL_OFS, mc(1'b0, MODE_PHASE, 2'b11, CS_EXT_RISE));
    tick(2);
    check("phase set up", 32'(pin_q.wave_out), 32'h1);
    tick(504);
    check("phase clear down", 32'(pin_q.wave_out), 32'h0);
    rd_chk("phase count", COUNT_OFS, 32'h2);
    $display("test phase pwm done");

    for (int i = 0; i < 5; i++)
    begin
      wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_STOP));
      wr(COUNT_OFS, 32'h0);
      wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, 3'(i + 1)));
      // the stop write below still ticks on its three edges
      repeat (20 * dv[i] - 3) @(posedge hclk);
      wr(MODE_CTRL_OFS, mc(1'b0, MODE_NORMAL, 2'b00, CS_STOP));
      xfer(1'b0, COUNT_OFS, 32'h0, rd);
      check("prescale", rd, 32'h14);
    end
    repeat (50) @(posedge hclk);
    rd_chk("stopped", COUNT_OFS, rd);
    $display("test clock select done");
    conclude();
  end
endmodule
`default_nettype wire
